// ### design/bridge_map.svh
`ifndef BRIDGE_MAP_SVH
`define BRIDGE_MAP_SVH

// **********
// response encodings
// **********
`define RESP_OKAY      2'h0
`define RESP_EXOKAY    2'h1
`define RESP_SLVERR    2'h2
`define RESP_DECERR    2'h3

// **********
// burst types
// **********
`define BURST_FIXED    2'h0
`define BURST_INCR     2'h1
`define BURST_WRAP     2'h2

// **********
// default sizes
// **********
`define ID_W_DEF       4
`define DATA_W_DEF     32
`define ADDR_W         32
`define LEN_W          8
`define IRQ_W          4
`define FIFO_DEPTH_DEF 16

// **********
// reset values
// **********
`define RST_CLEAR      1'b0
`define RST_READY      1'b1

`endif

// ### design/bridge_pkg.sv
package bridge_pkg;

  // **********
  // shared types
  // **********
  typedef logic [1:0] resp_t;
  typedef logic [1:0] burst_t;
  typedef logic [1:0] size_t;
  typedef logic [7:0] len_t;
  typedef logic [31:0] addr_t;
  typedef logic [3:0] irq_t;

  typedef enum logic {
    ST_IDLE,
    ST_BUSY
  } state_t;

endpackage

// ### design/bridge_axi_if.sv
`timescale 1ns/1ps

interface bridge_axi_if #(
  parameter int ID_W   = 4,
  parameter int DATA_W = 32
);
  import bridge_pkg::*;

  // **********
  // write response channel
  // **********
  logic [ID_W-1:0]   bid;
  resp_t             bresp;
  logic              bvalid;
  logic              bready;

  // **********
  // read address channel
  // **********
  logic [ID_W-1:0]   arid;
  addr_t             araddr;
  len_t              arlen;
  size_t             arsize;
  burst_t            arburst;
  logic              arvalid;
  logic              arready;

  // **********
  // read data channel
  // **********
  logic [ID_W-1:0]   rid;
  logic [DATA_W-1:0] rdata;
  resp_t             rresp;
  logic              rlast;
  logic              rvalid;
  logic              rready;

  // **********
  // level interrupts
  // **********
  irq_t              local_to_remote_irq_in;
  irq_t              remote_to_local_irq_out;

  modport port (
    output bid, bresp, bvalid, input bready,
    input arid, araddr, arlen, arsize, arburst, arvalid, output arready,
    output rid, rdata, rresp, rlast, rvalid, input rready,
    input local_to_remote_irq_in, output remote_to_local_irq_out
  );

  modport master (
    input bid, bresp, bvalid, output bready,
    output arid, araddr, arlen, arsize, arburst, arvalid, input arready,
    input rid, rdata, rresp, rlast, rvalid, output rready,
    output local_to_remote_irq_in, input remote_to_local_irq_out
  );

endinterface

// ### design/bridge_port_end.sv
// Functional notes
// - write response id equals completed write id
// - id width one to six, all channels
// - write status uses the four encodings
// - write response valid only when response held
// - master drives write response ready honestly
// - start address only, beats derived internally
// - master length sets exact beat count
// - burst type and size drive address steps
// - master holds read address until ready
// - read address ready only when acceptable
// - read data id from accepted address
// - read data width 32 or 64
// - last flag on final beat only
// - read valid only with data available
// - master drives read ready honestly
// - read status uses the four encodings
// - four local interrupts forwarded to link
// - four link interrupts reproduced locally
// - all port signals on one clock
// - asynchronous reset clears all control state except fifo input ready, which resets to one
`timescale 1ns/1ps
`include "bridge_map.svh"

// **********
// fifo in the read data path
// **********
module bridge_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // fill side
  input  wire logic             in_valid_i,
  output      logic             in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // drain side
  output      logic             out_valid_o,
  input  wire logic             out_ready_i,
  output      logic [WIDTH-1:0] out_data_o
);
  // depth must be a power of two so the pointers wrap by themselves
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  logic [AW:0]      count_next;
  logic             in_ready_reg;
  wire              push;
  wire              pop;

  assign push        = in_valid_i & in_ready_reg;
  assign pop         = out_valid_o & out_ready_i;
  assign out_valid_o = (count_reg != '0);
  assign in_ready_o  = in_ready_reg;
  assign out_data_o  = mem_reg[rd_ptr_reg];
  assign count_next  = count_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

  genvar g;
  for (g = 0; g < DEPTH; g++) begin : g_entry
    always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
        mem_reg[g] <= '0;
      end else if (push && (wr_ptr_reg == AW'(g))) begin
        mem_reg[g] <= in_data_i;
      end
    end
  end

  // ready is registered from the next count, so full never lies
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_ptr_reg   <= '0;
      rd_ptr_reg   <= '0;
      count_reg    <= '0;
      in_ready_reg <= `RST_READY;
    end else begin
      wr_ptr_reg   <= push ? wr_ptr_reg + AW'(1) : wr_ptr_reg;
      rd_ptr_reg   <= pop ? rd_ptr_reg + AW'(1) : rd_ptr_reg;
      count_reg    <= count_next;
      in_ready_reg <= (count_next != (AW + 1)'(DEPTH));
    end
  end

endmodule

// **********
// slave port end of the bridge
// **********
module bridge_port_end #(
  parameter int ID_W       = `ID_W_DEF,
  parameter int DATA_W     = `DATA_W_DEF,
  parameter int FIFO_DEPTH = `FIFO_DEPTH_DEF
) (
  // clock and reset
  input  wire logic              CLK_I,
  input  wire logic              RST_I,
  // local axi side
  bridge_axi_if.port             axi,
  // beat requests toward the link
  output      logic              BEAT_VALID_O,
  input  wire logic              BEAT_READY_I,
  output      bridge_pkg::addr_t BEAT_ADDR_O,
  output      bridge_pkg::size_t BEAT_SIZE_O,
  // read data back from the link
  input  wire logic              RET_VALID_I,
  output      logic              RET_READY_O,
  input  wire logic [DATA_W-1:0] RET_DATA_I,
  input  wire bridge_pkg::resp_t RET_RESP_I,
  // write responses from the link
  input  wire logic              WR_RESP_VALID_I,
  output      logic              WR_RESP_READY_O,
  input  wire logic [ID_W-1:0]   WR_RESP_ID_I,
  input  wire bridge_pkg::resp_t WR_RESP_CODE_I,
  // interrupt levels on the link
  output      bridge_pkg::irq_t  IRQ_TO_LINK_O,
  input  wire bridge_pkg::irq_t  IRQ_FROM_LINK_I
);
  import bridge_pkg::*;

  localparam int FW = ID_W + 1 + 2 + DATA_W;

  // **********
  // burst state
  // **********
  state_t            state_reg;
  state_t            state_next;
  addr_t             addr_reg;
  len_t              len_reg;
  size_t             size_reg;
  burst_t            burst_reg;
  logic [ID_W-1:0]   id_reg;
  len_t              req_left_reg;
  len_t              ret_left_reg;
  logic              beat_valid_reg;
  logic              arready_reg;

  // read data output stage
  logic              rvalid_reg;
  logic [ID_W-1:0]   rid_reg;
  logic [DATA_W-1:0] rdata_reg;
  resp_t             rresp_reg;
  logic              rlast_reg;

  // write response stage
  logic              bvalid_reg;
  logic              bvalid_next;
  logic              wr_free_reg;
  logic [ID_W-1:0]   bid_reg;
  resp_t             bresp_reg;

  irq_t              irq_link_reg;
  irq_t              irq_local_reg;

  // **********
  // decode
  // **********
  wire               ar_take;
  wire               beat_take;
  wire               ret_in_valid;
  wire               ret_push;
  wire               ret_final;
  wire               fifo_in_ready;
  wire               fifo_out_valid;
  wire               fifo_out_ready;
  wire [FW-1:0]      fifo_in_data;
  wire [FW-1:0]      fifo_out_data;
  wire               r_load;
  wire               b_load;
  addr_t             addr_inc;
  addr_t             wrap_span;
  addr_t             wrap_mask;
  addr_t             addr_incr;
  addr_t             addr_wrap;
  addr_t             addr_step;

  // read address accepted only while idle
  assign ar_take      = axi.arvalid & arready_reg;
  assign beat_take    = beat_valid_reg & BEAT_READY_I;
  // beat address from size and burst type
  assign addr_inc     = 32'h1 << size_reg;
  assign wrap_span    = ({24'h0, len_reg} + 32'h1) << size_reg;
  assign wrap_mask    = wrap_span - 32'h1;
  assign addr_incr    = addr_reg + addr_inc;
  assign addr_wrap    = (addr_reg & ~wrap_mask) | (addr_incr & wrap_mask);
  assign addr_step    = (burst_reg == `BURST_FIXED) ? addr_reg :
                        (burst_reg == `BURST_WRAP) ? addr_wrap : addr_incr;
  // returns only count while a burst is open
  assign ret_in_valid = RET_VALID_I & (state_reg == ST_BUSY);
  assign ret_push     = ret_in_valid & fifo_in_ready;
  assign ret_final    = ret_push & (ret_left_reg == 8'h00);
  // id and last tagged on entry into the fifo
  assign fifo_in_data = {id_reg, (ret_left_reg == 8'h00), RET_RESP_I, RET_DATA_I};
  assign fifo_out_ready = ~rvalid_reg | axi.rready;
  assign r_load       = fifo_out_valid & fifo_out_ready;
  assign b_load       = WR_RESP_VALID_I & wr_free_reg;
  assign bvalid_next  = b_load | (bvalid_reg & ~axi.bready);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (ar_take) begin
          state_next = ST_BUSY;
        end
      end
      ST_BUSY: begin
        if (ret_final) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  bridge_fifo #(
    .WIDTH       (FW),
    .DEPTH       (FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (CLK_I),
    .rst_i       (RST_I),
    .in_valid_i  (ret_in_valid),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (fifo_in_data),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (fifo_out_ready),
    .out_data_o  (fifo_out_data)
  );

  // **********
  // read address and beat requests
  // **********
  // async reset clear
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      state_reg   <= ST_IDLE;
      arready_reg <= `RST_CLEAR;
    end else begin
      state_reg   <= state_next;
      arready_reg <= (state_next == ST_IDLE) & ~ar_take;
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      addr_reg  <= '0;
      len_reg   <= '0;
      size_reg  <= '0;
      burst_reg <= '0;
      id_reg    <= '0;
    end else if (ar_take) begin
      addr_reg  <= axi.araddr;
      len_reg   <= axi.arlen;
      size_reg  <= axi.arsize;
      burst_reg <= axi.arburst;
      id_reg    <= axi.arid;
    end else if (beat_take) begin
      addr_reg  <= addr_step;
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      beat_valid_reg <= `RST_CLEAR;
      req_left_reg   <= '0;
      ret_left_reg   <= '0;
    end else begin
      if (ar_take) begin
        beat_valid_reg <= 1'b1;
        req_left_reg   <= axi.arlen;
      end else if (beat_take) begin
        beat_valid_reg <= (req_left_reg != 8'h00);
        req_left_reg   <= req_left_reg - 8'h01;
      end
      if (ar_take) begin
        ret_left_reg <= axi.arlen;
      end else if (ret_push) begin
        ret_left_reg <= ret_left_reg - 8'h01;
      end
    end
  end

  // **********
  // read data output stage
  // **********
  // valid only with data
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      rvalid_reg <= `RST_CLEAR;
    end else if (r_load) begin
      rvalid_reg <= 1'b1;
    end else if (axi.rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      rid_reg   <= '0;
      rlast_reg <= `RST_CLEAR;
      rresp_reg <= `RESP_OKAY;
      rdata_reg <= '0;
    end else if (r_load) begin
      {rid_reg, rlast_reg, rresp_reg, rdata_reg} <= fifo_out_data;
    end
  end

  // **********
  // write response stage
  // **********
  // valid only held
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      bvalid_reg  <= `RST_CLEAR;
      wr_free_reg <= `RST_CLEAR;
      bid_reg     <= '0;
      bresp_reg   <= `RESP_OKAY;
    end else begin
      bvalid_reg  <= bvalid_next;
      wr_free_reg <= ~bvalid_next;
      if (b_load) begin
        bid_reg   <= WR_RESP_ID_I;
        bresp_reg <= WR_RESP_CODE_I;
      end
    end
  end

  // **********
  // interrupt levels
  // **********
  // level forwarding
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      irq_link_reg  <= '0;
      irq_local_reg <= '0;
    end else begin
      irq_link_reg  <= axi.local_to_remote_irq_in;
      irq_local_reg <= IRQ_FROM_LINK_I;
    end
  end

  assign axi.arready                 = arready_reg;
  assign axi.rvalid                  = rvalid_reg;
  assign axi.rid                     = rid_reg;
  assign axi.rdata                   = rdata_reg;
  assign axi.rresp                   = rresp_reg;
  assign axi.rlast                   = rlast_reg;
  assign axi.bvalid                  = bvalid_reg;
  assign axi.bid                     = bid_reg;
  assign axi.bresp                   = bresp_reg;
  assign axi.remote_to_local_irq_out = irq_local_reg;
  assign BEAT_VALID_O                = beat_valid_reg;
  assign BEAT_ADDR_O                 = addr_reg;
  assign BEAT_SIZE_O                 = size_reg;
  assign RET_READY_O                 = fifo_in_ready;
  assign WR_RESP_READY_O             = wr_free_reg;
  assign IRQ_TO_LINK_O               = irq_link_reg;

endmodule

// ### design/bridge_master_end.sv
`timescale 1ns/1ps
`include "bridge_map.svh"

// **********
// local master end of the bridge port
// **********
module bridge_master_end #(
  parameter int ID_W   = `ID_W_DEF,
  parameter int DATA_W = `DATA_W_DEF
) (
  // clock and reset
  input  wire logic               CLK_I,
  input  wire logic               RST_I,
  // axi side
  bridge_axi_if.master            axi,
  // read commands
  input  wire logic               CMD_VALID_I,
  output      logic               CMD_READY_O,
  input  wire logic [ID_W-1:0]    CMD_ID_I,
  input  wire bridge_pkg::addr_t  CMD_ADDR_I,
  input  wire bridge_pkg::len_t   CMD_LEN_I,
  input  wire bridge_pkg::size_t  CMD_SIZE_I,
  input  wire bridge_pkg::burst_t CMD_BURST_I,
  // read data out
  input  wire logic               RD_STALL_I,
  output      logic               RD_VALID_O,
  output      logic [ID_W-1:0]    RD_ID_O,
  output      logic [DATA_W-1:0]  RD_DATA_O,
  output      bridge_pkg::resp_t  RD_RESP_O,
  output      logic               RD_LAST_O,
  // write responses out
  input  wire logic               WR_STALL_I,
  output      logic               WR_RESP_VALID_O,
  output      logic [ID_W-1:0]    WR_RESP_ID_O,
  output      bridge_pkg::resp_t  WR_RESP_CODE_O,
  // interrupt levels
  input  wire bridge_pkg::irq_t   IRQ_RAISE_I,
  output      bridge_pkg::irq_t   IRQ_SEEN_O
);
  import bridge_pkg::*;

  logic              arvalid_reg;
  logic              cmd_free_reg;
  logic [ID_W-1:0]   arid_reg;
  addr_t             araddr_reg;
  len_t              arlen_reg;
  size_t             arsize_reg;
  burst_t            arburst_reg;
  logic              rready_reg;
  logic              bready_reg;
  logic              rd_valid_reg;
  logic [ID_W-1:0]   rd_id_reg;
  logic [DATA_W-1:0] rd_data_reg;
  resp_t             rd_resp_reg;
  logic              rd_last_reg;
  logic              wr_valid_reg;
  logic [ID_W-1:0]   wr_id_reg;
  resp_t             wr_code_reg;
  irq_t              irq_out_reg;
  irq_t              irq_in_reg;

  wire               cmd_take;
  wire               arvalid_next;
  wire               r_take;
  wire               b_take;

  assign cmd_take     = CMD_VALID_I & cmd_free_reg;
  assign arvalid_next = cmd_take | (arvalid_reg & ~axi.arready);
  assign r_take       = axi.rvalid & rready_reg;
  assign b_take       = axi.bvalid & bready_reg;

  // **********
  // read address
  // **********
  // hold until ready
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      arvalid_reg  <= `RST_CLEAR;
      cmd_free_reg <= `RST_CLEAR;
      arid_reg     <= '0;
      araddr_reg   <= '0;
      arlen_reg    <= '0;
      arsize_reg   <= '0;
      arburst_reg  <= `BURST_INCR;
    end else begin
      arvalid_reg  <= arvalid_next;
      cmd_free_reg <= ~arvalid_next;
      if (cmd_take) begin
        arid_reg    <= CMD_ID_I;
        araddr_reg  <= CMD_ADDR_I;
        arlen_reg   <= CMD_LEN_I;
        arsize_reg  <= CMD_SIZE_I;
        arburst_reg <= CMD_BURST_I;
      end
    end
  end

  // **********
  // read data and write response
  // **********
  // ready from stall
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      rready_reg   <= `RST_CLEAR;
      bready_reg   <= `RST_CLEAR;
      rd_valid_reg <= `RST_CLEAR;
      wr_valid_reg <= `RST_CLEAR;
    end else begin
      rready_reg   <= ~RD_STALL_I;
      bready_reg   <= ~WR_STALL_I;
      rd_valid_reg <= r_take;
      wr_valid_reg <= b_take;
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      rd_id_reg   <= '0;
      rd_data_reg <= '0;
      rd_resp_reg <= `RESP_OKAY;
      rd_last_reg <= `RST_CLEAR;
      wr_id_reg   <= '0;
      wr_code_reg <= `RESP_OKAY;
    end else begin
      if (r_take) begin
        rd_id_reg   <= axi.rid;
        rd_data_reg <= axi.rdata;
        rd_resp_reg <= axi.rresp;
        rd_last_reg <= axi.rlast;
      end
      if (b_take) begin
        wr_id_reg   <= axi.bid;
        wr_code_reg <= axi.bresp;
      end
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      irq_out_reg <= '0;
      irq_in_reg  <= '0;
    end else begin
      irq_out_reg <= IRQ_RAISE_I;
      irq_in_reg  <= axi.remote_to_local_irq_out;
    end
  end

  assign axi.arvalid                = arvalid_reg;
  assign axi.arid                   = arid_reg;
  assign axi.araddr                 = araddr_reg;
  assign axi.arlen                  = arlen_reg;
  assign axi.arsize                 = arsize_reg;
  assign axi.arburst                = arburst_reg;
  assign axi.rready                 = rready_reg;
  assign axi.bready                 = bready_reg;
  assign axi.local_to_remote_irq_in = irq_out_reg;
  assign CMD_READY_O                = cmd_free_reg;
  assign RD_VALID_O                 = rd_valid_reg;
  assign RD_ID_O                    = rd_id_reg;
  assign RD_DATA_O                  = rd_data_reg;
  assign RD_RESP_O                  = rd_resp_reg;
  assign RD_LAST_O                  = rd_last_reg;
  assign WR_RESP_VALID_O            = wr_valid_reg;
  assign WR_RESP_ID_O               = wr_id_reg;
  assign WR_RESP_CODE_O             = wr_code_reg;
  assign IRQ_SEEN_O                 = irq_in_reg;

endmodule

// ### test/bridge_assertions.sv
`timescale 1ns/1ps
// **********
// checks on the axi wires between the ends
// **********
module bridge_assertions
  import bridge_pkg::*;
#(
  parameter int ID_W   = 4,
  parameter int DATA_W = 32
) (
  // clock and reset
  input wire logic              CLK_I,
  input wire logic              RST_I,
  // write response
  input wire logic [ID_W-1:0]   bid,
  input wire resp_t             bresp,
  input wire logic              bvalid,
  input wire logic              bready,
  // read address
  input wire logic [ID_W-1:0]   arid,
  input wire addr_t             araddr,
  input wire len_t              arlen,
  input wire size_t             arsize,
  input wire burst_t            arburst,
  input wire logic              arvalid,
  input wire logic              arready,
  // read data
  input wire logic [ID_W-1:0]   rid,
  input wire logic [DATA_W-1:0] rdata,
  input wire resp_t             rresp,
  input wire logic              rlast,
  input wire logic              rvalid,
  input wire logic              rready
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  logic [ID_W-1:0] id_reg;
  len_t            len_reg;
  len_t            cnt_reg;
  logic            open_reg;
  wire             ar_hs = arvalid && arready;
  wire             r_hs  = rvalid && rready;
  // one burst at a time, so a single tracker is enough
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      id_reg   <= '0;
      len_reg  <= '0;
      cnt_reg  <= '0;
      open_reg <= 1'b0;
    end else if (ar_hs) begin
      id_reg   <= arid;
      len_reg  <= arlen;
      cnt_reg  <= '0;
      open_reg <= 1'b1;
    end else if (r_hs) begin
      cnt_reg  <= cnt_reg + 8'h01;
      open_reg <= !rlast;
    end
  end
  a_b_payload_hold: assert property (bvalid && !bready |=> bvalid && $stable({bid, bresp}))
    else $error("write response dropped before ready");
  a_r_payload_hold: assert property (rvalid && !rready |=> rvalid && $stable({rid, rdata, rresp, rlast}))
    else $error("read beat dropped before ready");
  a_ar_master_hold: assert property (arvalid && !arready |=> arvalid && $stable({arid, araddr, arlen, arsize, arburst}))
    else $error("read address changed before ready");
  a_ar_ready_close: assert property (ar_hs |=> !arready)
    else $error("second address taken while burst open");
  a_rid_matches: assert property (rvalid |-> rid == id_reg)
    else $error("read id differs from address id");
  a_rlast_final: assert property (rvalid |-> rlast == (cnt_reg == len_reg))
    else $error("last flag on wrong beat");
  a_r_in_burst: assert property (rvalid |-> open_reg)
    else $error("read valid with no burst open");
  a_beat_bound: assert property (r_hs |-> cnt_reg <= len_reg)
    else $error("more beats than burst length");
endmodule

// ### test/bridge_axi_slave_port_resp_read_tb_top.sv
`timescale 1ns/1ps
`include "bridge_map.svh"
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin num_errors++; $display("BAD %s exp %h got %h", n, e, g); end end
module bridge_axi_slave_port_resp_read_tb_top;
  import bridge_pkg::*;
  logic        CLK_I = 0, RST_I = 1, BEAT_VALID_O, BEAT_READY_I, RET_READY_O, RET_VALID_I;
  logic        WR_RESP_READY_O, WR_RESP_VALID_I = 0, CMD_VALID_I = 0, CMD_READY_O, RD_STALL_I;
  logic        RD_VALID_O, RD_LAST_O, WR_STALL_I, WR_RESP_VALID_O;
  addr_t       BEAT_ADDR_O, CMD_ADDR_I, exp_a, bq[$], rq[$];
  size_t       BEAT_SIZE_O, CMD_SIZE_I;
  len_t        CMD_LEN_I;
  burst_t      CMD_BURST_I;
  logic [31:0] RET_DATA_I, RD_DATA_O;
  resp_t       RET_RESP_I, RD_RESP_O, WR_RESP_CODE_I, WR_RESP_CODE_O;
  logic [3:0]  WR_RESP_ID_I, WR_RESP_ID_O, CMD_ID_I, RD_ID_O;
  irq_t        IRQ_TO_LINK_O, IRQ_FROM_LINK_I, IRQ_RAISE_I, IRQ_SEEN_O;
  int          num_errors = 0, cmp_count = 0, rd_n, wr_n, cyc = 0, i;
  logic [15:0] lf = 16'h97CD;
  bit          hold = 0, full_seen;
  // **********
  // expectation helpers
  // **********
  function automatic logic [15:0] step(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  function automatic addr_t nxt(input addr_t a, input len_t l, input size_t s, input burst_t b);
    addr_t m;
    m = (({24'h0, l} + 32'h1) << s) - 32'h1;
    if (b == `BURST_FIXED) return a;
    if (b == `BURST_INCR) return a + (32'h1 << s);
    return (a & ~m) | ((a + (32'h1 << s)) & m);
  endfunction
  function automatic logic [31:0] dat(input addr_t a);
    return a ^ 32'h5A5A0000;
  endfunction
  // **********
  // the two ends and the checker
  // **********
  bridge_axi_if #(.ID_W(4), .DATA_W(32)) u_if ();
  bridge_port_end #(.ID_W(4), .DATA_W(32), .FIFO_DEPTH(16)) u_bridge_port_end (.CLK_I, .RST_I, .axi(u_if.port),
    .BEAT_VALID_O, .BEAT_READY_I, .BEAT_ADDR_O, .BEAT_SIZE_O, .RET_VALID_I, .RET_READY_O, .RET_DATA_I, .RET_RESP_I,
    .WR_RESP_VALID_I, .WR_RESP_READY_O, .WR_RESP_ID_I, .WR_RESP_CODE_I, .IRQ_TO_LINK_O, .IRQ_FROM_LINK_I);
  bridge_master_end #(.ID_W(4), .DATA_W(32)) u_bridge_master_end (.CLK_I, .RST_I, .axi(u_if.master), .CMD_VALID_I,
    .CMD_READY_O, .CMD_ID_I, .CMD_ADDR_I, .CMD_LEN_I, .CMD_SIZE_I, .CMD_BURST_I, .RD_STALL_I, .RD_VALID_O, .RD_ID_O,
    .RD_DATA_O, .RD_RESP_O, .RD_LAST_O, .WR_STALL_I, .WR_RESP_VALID_O, .WR_RESP_ID_O, .WR_RESP_CODE_O, .IRQ_RAISE_I,
    .IRQ_SEEN_O);
  bridge_assertions #(.ID_W(4), .DATA_W(32)) u_chk (.CLK_I, .RST_I, .bid(u_if.bid), .bresp(u_if.bresp),
    .bvalid(u_if.bvalid), .bready(u_if.bready), .arid(u_if.arid), .araddr(u_if.araddr), .arlen(u_if.arlen),
    .arsize(u_if.arsize), .arburst(u_if.arburst), .arvalid(u_if.arvalid), .arready(u_if.arready), .rid(u_if.rid),
    .rdata(u_if.rdata), .rresp(u_if.rresp), .rlast(u_if.rlast), .rvalid(u_if.rvalid), .rready(u_if.rready));
  initial forever #10 CLK_I = ~CLK_I;
  // **********
  // link side model and monitors
  // **********
  always @(negedge CLK_I) begin
    lf = step(lf);
    BEAT_READY_I <= lf[0] | lf[1];
    RD_STALL_I   <= hold | (lf[2] & lf[3]);
    WR_STALL_I   <= lf[4];
    RET_VALID_I  <= bq.size() > 0;
    if (bq.size() > 0) begin
      RET_DATA_I <= dat(bq[0]);
      RET_RESP_I <= bq[0][5:4];
    end
  end
  always @(posedge CLK_I) begin
    cyc++;
    if (BEAT_VALID_O && BEAT_READY_I) begin
      `CHK("beat_addr", exp_a, BEAT_ADDR_O)
      bq.push_back(exp_a);
      rq.push_back(exp_a);
      exp_a = nxt(exp_a, CMD_LEN_I, CMD_SIZE_I, CMD_BURST_I);
    end
    if (RET_VALID_I && RET_READY_O) void'(bq.pop_front());
    if (hold && !RET_READY_O) full_seen = 1;
    if (RD_VALID_O) begin
      `CHK("rdata", dat(rq[0]), RD_DATA_O)
      `CHK("rresp", rq[0][5:4], RD_RESP_O)
      `CHK("rid", CMD_ID_I, RD_ID_O)
      `CHK("rlast", rd_n == int'(CMD_LEN_I), RD_LAST_O)
      void'(rq.pop_front());
      rd_n++;
    end
    if (WR_RESP_VALID_O) begin
      `CHK("bid", WR_RESP_ID_I, WR_RESP_ID_O)
      `CHK("bresp", WR_RESP_CODE_I, WR_RESP_CODE_O)
      wr_n++;
    end
    if (cyc == 20000) begin
      num_errors++;
      tally_and_finish();
    end
  end
  // **********
  // transfer tasks
  // **********
  task automatic rd(input logic [3:0] id, input addr_t a, input len_t l, input size_t s, input burst_t b, input bit h);
    int t;
    @(negedge CLK_I);
    {hold, full_seen, rd_n, exp_a} = {h, 1'b0, 32'd0, a};
    {CMD_ID_I, CMD_ADDR_I, CMD_LEN_I, CMD_SIZE_I, CMD_BURST_I, CMD_VALID_I} = {id, a, l, s, b, 1'b1};
    do @(posedge CLK_I); while (CMD_READY_O !== 1'b1);
    @(negedge CLK_I) CMD_VALID_I = 0;
    // stall long enough to fill the fifo, then drain it
    for (t = 0; t < 3000 && rd_n <= int'(l); t++) @(negedge CLK_I) if (t == 200) hold = 0;
    `CHK("beats", int'(l) + 1, rd_n)
    if (h) `CHK("fifo_full", 1'b1, full_seen)
  endtask
  task automatic wr(input logic [3:0] id, input resp_t c);
    int t;
    @(negedge CLK_I);
    {WR_RESP_ID_I, WR_RESP_CODE_I, WR_RESP_VALID_I, wr_n} = {id, c, 1'b1, 32'd0};
    do @(posedge CLK_I); while (WR_RESP_READY_O !== 1'b1);
    @(negedge CLK_I) WR_RESP_VALID_I = 0;
    for (t = 0; t < 100 && wr_n == 0; t++) @(negedge CLK_I);
    `CHK("b_count", 1, wr_n)
  endtask
  task automatic tally_and_finish();
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // **********
  // main sequence
  // **********
  initial begin
    repeat (6) @(posedge CLK_I);
    @(negedge CLK_I) RST_I = 0;
    rd(4'h3, 32'h100, 8'd0, 2'd2, `BURST_INCR, 0);
    rd(4'hA, 32'h204, 8'd3, 2'd2, `BURST_WRAP, 0);
    rd(4'h5, 32'h40, 8'd23, 2'd2, `BURST_INCR, 1);
    for (i = 0; i < 12; i++) begin
      lf = step(lf);
      rd(lf[3:0], {16'h0, lf & 16'hFFFC}, (i % 3 == 2) ? 8'd7 : {5'h0, lf[6:4]}, lf[9] ? 2'd2 : {1'b0, lf[8]},
         2'(i % 3), 0);
    end
    for (i = 0; i < 4; i++) wr(lf[3:0] ^ 4'(i), 2'(i));
    for (i = 0; i < 2; i++) begin
      @(negedge CLK_I) {IRQ_RAISE_I, IRQ_FROM_LINK_I} = i ? 8'hA5 : 8'h5A;
      repeat (3) @(negedge CLK_I);
      `CHK("irq_out", IRQ_RAISE_I, IRQ_TO_LINK_O)
      `CHK("irq_in", IRQ_FROM_LINK_I, IRQ_SEEN_O)
    end
    tally_and_finish();
  end
endmodule
